// ==== cpd_pkg.sv ====
// cpd_pkg: control latch layout, reset values and timing constants
// assumes a single 200 MHz clock domain
package cpd_pkg;
    localparam int unsigned CPD_CLK_MHZ = 200;
    localparam logic [0:0] CPD_ADDR_WIDTH_LATCH = 1'h0;
    localparam logic [0:0] CPD_ADDR_CONTROL = 1'h1;
    localparam logic [7:0] CPD_CTRL_RESET = 8'h47;
    localparam logic [7:0] CPD_WIDTH_RESET = 8'h00;
    localparam int unsigned CPD_DT_LSB = 0;
    localparam int unsigned CPD_DT_MSB = 2;
    localparam int unsigned CPD_LOCK_BIT = 4;
    localparam int unsigned CPD_DIV_BIT = 5;
    localparam int unsigned CPD_RES_BIT = 6;
    localparam int unsigned CPD_STOP_BIT = 7;
    localparam logic [7:0] CPD_LOCKED_KEEP_MASK = 8'h7f;
    localparam logic [1:0] CPD_DT_STEP_CLKS = 2'h2;
    localparam logic [7:0] CPD_PERIOD_7BIT_MAX = 8'h7f;
    localparam logic [7:0] CPD_PERIOD_8BIT_MAX = 8'hff;
    localparam logic [8:0] CPD_FULL_7BIT = 9'h080;
    localparam logic [8:0] CPD_FULL_8BIT = 9'h100;
    typedef enum logic [2:0] {
        CPD_ST_IDLE = 3'b001,
        CPD_ST_DEAD = 3'b010,
        CPD_ST_ON = 3'b100
    } cpd_leg_type;
endpackage

// ==== cpd_deadtime.sv ====
// cpd_deadtime: dead-time counter that blanks both legs after any turn-off when the code is non-zero
// assumes the raw comparator level arrives on the same clock
`timescale 1ns/1ps
module cpd_deadtime
    import cpd_pkg::*;
#(
    parameter int unsigned DT_W = 3
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic raw_high,
    input wire logic enable,
    input wire logic [DT_W-1:0] dt_code,
    output logic leg_a,
    output logic leg_b
);
    logic [DT_W+1:0] cnt_q;
    logic raw_q;
    logic busy;
    logic fall;

    assign busy = (cnt_q != '0);
    assign fall = enable && (raw_high != raw_q);

    always_ff @(posedge mclk) begin
        if (srst || !enable) begin
            raw_q <= raw_high;
        end else begin
            raw_q <= raw_high;
        end
    end

    // restart blanking on every comparator edge; code zero gives none
    always_ff @(posedge mclk) begin
        if (srst || !enable) begin
            cnt_q <= '0;
        end else if (fall) begin
            cnt_q <= (DT_W+2)'({dt_code, 1'b0});
            if (dt_code == '0) begin
                cnt_q <= '0;
            end
        end else if (busy) begin
            cnt_q <= cnt_q - (DT_W+2)'(1);
        end
    end

    // an edge in progress or blanking keeps both legs off
    always_ff @(posedge mclk) begin
        if (srst || !enable) begin
            leg_a <= 1'b0;
            leg_b <= 1'b0;
        end else if ((fall && dt_code != '0) || (busy && cnt_q != (DT_W+2)'(1))) begin
            leg_a <= 1'b0;
            leg_b <= 1'b0;
        end else begin
            leg_a <= raw_high;
            leg_b <= !raw_high;
        end
    end
endmodule

// ==== cpd_pwm.sv ====
// What this block does
// - resolution bit zero gives 7-bit counter
// - divide bit halves the counter clock
// - periods of 128, 256 or 512 clocks
// - reset loads control latch 01000111
// - reset gives max dead-time, outputs stopped
// - lock cleared only by reset
// - locked: only stop bit stays writable
// - no power-up reset; latches await reset
// - reset clears pulse width latch
// - one unlocked control write updates all bits
// - dead-time code zero adds no blanking
// - each turn-off blanks both for dead-time
// - too-short on-time keeps that output off
// - no dead-time at 0 or 100 percent
// - new width acts one clock after write
// - unsynchronized width writes accepted safely
// - stop or disable forces outputs low
// - dead-time codes zero to seven valid
// - width sets first output high time
//
// cpd_pwm: complementary pwm generator with control and width latches
// assumes register port on mclk; output_disable is an asynchronous pin
`timescale 1ns/1ps
module cpd_pwm
    import cpd_pkg::*;
#(
    parameter int unsigned DATA_W = 8
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [0:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic output_disable,
    output logic pwm_out_high_side,
    output logic pwm_out_complement,
    output logic outputs_enabled,
    output logic [DATA_W-1:0] pwm_count
);
    logic [7:0] ctrl_q;
    logic [7:0] pulse_width_value;
    logic [7:0] cnt_q;
    logic prescale_q;
    logic tick;
    logic period_end;
    logic [7:0] period_max;
    logic [8:0] full_width;
    logic [8:0] width_eff;
    logic raw_high;
    logic dis_meta_q;
    logic dis_sync_q;
    logic run_q;
    logic stop_now;
    logic deadtime_code_b0;
    logic deadtime_code_b1;
    logic deadtime_code_b2;

    assign deadtime_code_b0 = ctrl_q[CPD_DT_LSB];
    assign deadtime_code_b1 = ctrl_q[CPD_DT_LSB+1];
    assign deadtime_code_b2 = ctrl_q[CPD_DT_MSB];

    // pin synchroniser for the disable input
    always_ff @(posedge mclk) begin
        if (srst) begin
            dis_meta_q <= 1'b0;
            dis_sync_q <= 1'b0;
        end else begin
            dis_meta_q <= output_disable;
            dis_sync_q <= dis_meta_q;
        end
    end

    // control latch: lock keeps all but stop; lock only reset clears
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_q <= CPD_CTRL_RESET;
        end else if (reg_wr && reg_addr == CPD_ADDR_CONTROL) begin
            if (ctrl_q[CPD_LOCK_BIT]) begin
                ctrl_q <= (ctrl_q & CPD_LOCKED_KEEP_MASK)
                    | (reg_wdata[7:0] & ~CPD_LOCKED_KEEP_MASK);
            end else begin
                ctrl_q <= reg_wdata[7:0];
            end
        end
    end

    // width latch, taken on any cycle with no alignment needed
    always_ff @(posedge mclk) begin
        if (srst) begin
            pulse_width_value <= CPD_WIDTH_RESET;
        end else if (reg_wr && reg_addr == CPD_ADDR_WIDTH_LATCH) begin
            pulse_width_value <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= (reg_addr == CPD_ADDR_CONTROL) ? DATA_W'(ctrl_q)
                : DATA_W'(pulse_width_value);
        end else begin
            reg_rdata <= '0;
        end
    end

    // prescaler: tick every clock or every second clock
    assign tick = !ctrl_q[CPD_DIV_BIT] || prescale_q;
    always_ff @(posedge mclk) begin
        if (srst) begin
            prescale_q <= 1'b0;
        end else begin
            prescale_q <= !prescale_q;
        end
    end

    assign period_max = ctrl_q[CPD_RES_BIT] ? CPD_PERIOD_8BIT_MAX
        : CPD_PERIOD_7BIT_MAX;
    assign full_width = ctrl_q[CPD_RES_BIT] ? CPD_FULL_8BIT : CPD_FULL_7BIT;
    assign period_end = tick && (cnt_q >= period_max);

    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt_q <= '0;
        end else if (period_end) begin
            cnt_q <= '0;
        end else if (tick) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // 7-bit mode: any width with bit 7 set means full on
    always_comb begin
        if (!ctrl_q[CPD_RES_BIT] && pulse_width_value[7]) begin
            width_eff = full_width;
        end else if (ctrl_q[CPD_RES_BIT] && pulse_width_value == 8'hff) begin
            width_eff = full_width;
        end else begin
            width_eff = {1'b0, pulse_width_value};
        end
    end

    // live compare against the latch, so a write acts within the cycle
    assign raw_high = {1'b0, cnt_q} < width_eff;

    // stop or disable kills outputs at once; resume at period start only
    assign stop_now = !ctrl_q[CPD_STOP_BIT] || dis_sync_q;
    always_ff @(posedge mclk) begin
        if (srst) begin
            run_q <= 1'b0;
        end else if (stop_now) begin
            run_q <= 1'b0;
        end else if (period_end) begin
            run_q <= 1'b1;
        end
    end

    cpd_deadtime #(
        .DT_W(3)
    ) u_deadtime (
        .mclk(mclk),
        .srst(srst),
        .raw_high(raw_high),
        .enable(run_q && !stop_now),
        .dt_code({deadtime_code_b2, deadtime_code_b1, deadtime_code_b0}),
        .leg_a(pwm_out_high_side),
        .leg_b(pwm_out_complement)
    );

    always_ff @(posedge mclk) begin
        if (srst) begin
            outputs_enabled <= 1'b0;
            pwm_count <= '0;
        end else begin
            outputs_enabled <= run_q && !stop_now;
            pwm_count <= DATA_W'(cnt_q);
        end
    end
endmodule

// ==== cpd_pwm_properties.sv ====
// cpd_pwm_chk: port-level properties of the pwm block
// assumes one mclk domain and synchronous srst
`timescale 1ns/1ps
module cpd_pwm_chk (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [0:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic output_disable,
    input wire logic pwm_out_high_side,
    input wire logic pwm_out_complement,
    input wire logic outputs_enabled
);
    logic [7:0] ctrl_q;
    logic [7:0] width_q;
    logic hs;
    logic lo;
    assign hs = pwm_out_high_side;
    assign lo = pwm_out_complement;
    always_ff @(posedge mclk) begin
        if (srst)
            ctrl_q <= 8'h47;
        else if (reg_wr && reg_addr == 1'h1)
            ctrl_q <= ctrl_q[4] ? {reg_wdata[7], ctrl_q[6:0]} : reg_wdata;
    end
    always_ff @(posedge mclk) begin
        if (srst)
            width_q <= 8'h00;
        else if (reg_wr && reg_addr == 1'h0)
            width_q <= reg_wdata;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    sequence blank2;
        (!hs && !lo) [*2];
    endsequence
    sequence zero3;
        (width_q == 8'h00) [*3];
    endsequence
    chk_no_overlap: assert property (!(hs && lo)) else $error("both outputs on");
    chk_stop_low: assert property (reg_wr && reg_addr == 1'h1 && !reg_wdata[7] |->
        ##[1:3] (!hs && !lo)) else $error("stop did not force outputs low");
    chk_disable_low: assert property (output_disable |-> ##[1:4] (!hs && !lo))
        else $error("disable did not force outputs low");
    chk_reset_quiet: assert property ($fell(srst) |-> !hs && !lo && !outputs_enabled)
        else $error("outputs active after reset");
    chk_ctrl_read: assert property (reg_rd && reg_addr == 1'h1 |=> reg_rdata == ctrl_q)
        else $error("control readback wrong");
    chk_width_read: assert property (reg_rd && reg_addr == 1'h0 |=> reg_rdata == width_q)
        else $error("width readback wrong");
    chk_zero_duty: assert property (zero3 |-> !hs) else $error("high side on at zero width");
    chk_dead_blank: assert property (($fell(hs) || $fell(lo)) && ctrl_q[2:0] != 3'h0 |->
        blank2) else $error("dead time too short");
endmodule
bind cpd_pwm cpd_pwm_chk u_cpd_pwm_chk (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .output_disable(output_disable), .pwm_out_high_side(pwm_out_high_side),
    .pwm_out_complement(pwm_out_complement), .outputs_enabled(outputs_enabled));

// ==== cpd_host_model.sv ====
// cpd_host_model: host writing and reading the pwm latches
// assumes read data stand one cycle after the read strobe
`timescale 1ns/1ps
module cpd_host_model (
    input wire logic mclk,
    output logic [0:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 1'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task wr(input logic [0:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task rd(input logic [0:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task put_width(input int v);
        wr(1'h0, v < 0 ? 8'h00 : (v > 255 ? 8'hff : v[7:0]));
    endtask
endmodule

// ==== cpd_pwm_tb_top.sv ====
// cpd_pwm_tb_top: self-checking bench for the pwm block
// assumes the host model drives the register port
`timescale 1ns/1ps
module cpd_pwm_tb_top;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic output_disable = 1'b0;
    logic [0:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_wr;
    logic reg_rd;
    logic hs;
    logic lo;
    logic [15:0] h;
    logic [15:0] p;
    logic [7:0] d;
    int err_count = 0;
    int num_checks = 0;
    always #2.5 mclk = ~mclk;
    cpd_host_model u_cpd_host_model (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    cpd_pwm u_cpd_pwm (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .output_disable(output_disable), .pwm_out_high_side(hs), .pwm_out_complement(lo),
        .outputs_enabled(), .pwm_count());
    task tick;
        @(posedge mclk);
        #1;
    endtask
    task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task end_sim;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task meas;
        repeat (2) begin
            do tick; while (!hs);
            do tick; while (hs);
        end
        h = 16'h0;
        p = 16'h0;
        do begin
            tick;
            p++;
            h += hs;
        end while (h == 16'h0 || hs);
    endtask
    task cnt;
        repeat (600) tick;
        h = 16'h0;
        p = 16'h0;
        repeat (600) begin
            tick;
            h += hs;
            p += lo;
        end
    endtask
    task t_modes;
        u_cpd_host_model.put_width(64);
        for (int m = 0; m < 4; m++) begin
            u_cpd_host_model.wr(1'h1, {1'b1, m[0], m[1], 5'h00});
            meas;
            chk("period", p, 16'h80 << $countones(m[1:0]));
            chk("high", h, 16'h40 << m[1]);
        end
    endtask
    task t_dead_edges;
        u_cpd_host_model.wr(1'h1, 8'hc3);
        meas;
        chk("dead", h, 16'h3a);
        u_cpd_host_model.wr(1'h1, 8'hc7);
        u_cpd_host_model.put_width(2);
        cnt;
        chk("short", h, 16'h0);
        u_cpd_host_model.put_width(300);
        cnt;
        chk("full", {h[7:0], p[7:0]}, 16'h5800);
        u_cpd_host_model.put_width(-5);
        cnt;
        chk("zero", {h[7:0], p[7:0]}, 16'h0058);
    endtask
    task t_disable_lock;
        u_cpd_host_model.put_width(128);
        cnt;
        @(posedge mclk) output_disable <= 1'b1;
        repeat (6) tick;
        chk("off", {hs, lo}, 16'h0);
        @(posedge mclk) output_disable <= 1'b0;
        cnt;
        chk("back", {15'h0, h != 16'h0}, 16'h1);
        u_cpd_host_model.wr(1'h1, 8'hd0);
        u_cpd_host_model.wr(1'h1, 8'h05);
        u_cpd_host_model.rd(1'h1, d);
        chk("lock", d, 16'h50);
        @(posedge mclk) srst <= 1'b1;
        @(posedge mclk) srst <= 1'b0;
        tick;
        u_cpd_host_model.rd(1'h1, d);
        chk("ctrl", d, 16'h47);
        u_cpd_host_model.rd(1'h0, d);
        chk("width", d, 16'h0);
        chk("outs", {hs, lo}, 16'h0);
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        tick;
        t_modes;
        t_dead_edges;
        t_disable_lock;
        end_sim;
    end
    initial begin
        repeat (40000) @(posedge mclk);
        err_count++;
        end_sim;
    end
endmodule
